// ---- logic/fic_pkg.sv ----
// Package with constants and types for the flash image checksum block.
package fic_pkg;
  // Family variant codes.
  localparam logic [1:0] FIC_VAR_SINGLE_BOOT = 2'h0;
  localparam logic [1:0] FIC_VAR_DUAL_BOOT   = 2'h1;
  localparam logic [1:0] FIC_VAR_DUAL_PANEL  = 2'h2;
  localparam logic [1:0] FIC_VAR_DUAL_BOOT_X = 2'h3;
  // Upper configuration word index per variant group.
  localparam logic [2:0] FIC_CFG_HI_BASE = 3'h3;
  localparam logic [2:0] FIC_CFG_HI_EXT  = 3'h4;
  // Dual-boot exclusion window on the low sixteen address bits (0x1FCxFF00..0x1FCxFFFF).
  localparam logic [31:0] FIC_DB_WIN_MASK = 32'hFFF0FF00;
  localparam logic [31:0] FIC_DB_WIN_BASE = 32'h1FC0FF00;
  // Dual-panel exclusion window.
  localparam logic [31:0] FIC_DP_WIN_LO = 32'h1FC03F00;
  localparam logic [31:0] FIC_DP_WIN_HI = 32'h1FC03FFF;
  // Single-boot: final configuration bytes of boot flash.
  localparam int unsigned FIC_SB_CFG_BYTES = 16;
  // Byte source kinds.
  localparam logic [1:0] FIC_SRC_PROG = 2'h0;
  localparam logic [1:0] FIC_SRC_BOOT = 2'h1;
  localparam logic [1:0] FIC_SRC_CFG  = 2'h2;
  localparam logic [1:0] FIC_SRC_ID   = 2'h3;
  // Accumulator reset value.
  localparam logic [31:0] FIC_SUM_RESET = 32'h00000000;
  // Controller states.
  typedef enum logic [2:0] {
    FIC_ST_IDLE = 3'b001,
    FIC_ST_RUN  = 3'b010,
    FIC_ST_DONE = 3'b100
  } fic_state_e;
endpackage

// ---- logic/fic_skid_buf.sv ----
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module fic_skid_buf #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  wire              push = i_valid && o_ready && i_ce;
  wire              pop  = o_valid && i_ready && i_ce;

  // Ready only while a slot is free and the clock enable is high. A stalled drain
  // holds the source back, and a frozen block never signals ready for a word it drops.
  assign o_ready = i_ce && (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data  = mem[rd_ptr];

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; valid gates every read.
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= i_data;
  end
endmodule
`default_nettype wire

// ---- logic/fic_checksum.sv ----
// Streaming 32-bit flash image checksum engine.
//
// Overview of operation
// - Sum all qualifying bytes into 32-bit accumulator.
// - Result is two's complement of sum.
// - Configuration words ANDed with mask first.
// - Identifier word ANDed with mask first.
// - Configuration words zero to three or four.
// - Dual-boot skips boot window xFF00..xFFFF.
// - Dual-panel skips boot 0x1FC03F00..0x1FC03FFF.
// - Single-boot skips final sixteen boot bytes.
// - Only primary configuration words contribute.
// - Code-protected part reports zero checksum.
`timescale 1ns/1ps
`default_nettype none
module fic_checksum #(
  parameter logic [1:0]  VARIANT      = fic_pkg::FIC_VAR_SINGLE_BOOT,
  parameter logic [31:0] BOOT_END     = 32'h1FC02FFF,
  parameter logic [31:0] ID_MASK      = 32'h0FFFFFFF,
  parameter logic [31:0] CFG_MASK0    = 32'hFFFFFFFF,
  parameter logic [31:0] CFG_MASK1    = 32'hFFFFFFFF,
  parameter logic [31:0] CFG_MASK2    = 32'hFFFFFFFF,
  parameter logic [31:0] CFG_MASK3    = 32'hFFFFFFFF,
  parameter logic [31:0] CFG_MASK4    = 32'hFFFFFFFF
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_start,
  input  wire logic        i_code_protect,
  input  wire logic        i_byte_valid,
  output logic             o_byte_ready,
  input  wire logic [7:0]  i_byte,
  input  wire logic [31:0] i_byte_addr,
  input  wire logic [1:0]  i_byte_src,
  input  wire logic [2:0]  i_cfg_index,
  input  wire logic        i_cfg_alternate,
  input  wire logic [1:0]  i_byte_lane,
  input  wire logic        i_last,
  output logic             o_busy,
  output logic             o_done,
  output logic [31:0]      o_checksum
);
  // Buffered item: byte, address, source, index, alternate, lane, last.
  localparam int unsigned ITEM_W = 8 + 32 + 2 + 3 + 1 + 2 + 1;

  fic_pkg::fic_state_e state;
  fic_pkg::fic_state_e next_state;
  logic [31:0]         program_flash_sum;
  logic [31:0]         boot_flash_sum;
  logic [31:0]         masked_config_sum;
  logic [31:0]         id_sum;
  logic                protect_q;

  logic [ITEM_W-1:0] buf_in;
  logic [ITEM_W-1:0] buf_out;
  logic              buf_valid;
  logic              buf_ready;

  // Picks one byte lane of a masked word.
  function automatic logic [7:0] fic_lane(input logic [31:0] w, input logic [1:0] lane);
    fic_lane = w[{lane, 3'h0} +: 8];
  endfunction

  // Returns the mask of a configuration word index.
  function automatic logic [31:0] fic_cfg_mask(input logic [2:0] idx);
    case (idx)
      3'h0:    fic_cfg_mask = CFG_MASK0;
      3'h1:    fic_cfg_mask = CFG_MASK1;
      3'h2:    fic_cfg_mask = CFG_MASK2;
      3'h3:    fic_cfg_mask = CFG_MASK3;
      3'h4:    fic_cfg_mask = CFG_MASK4;
      default: fic_cfg_mask = 32'h00000000;
    endcase
  endfunction

  assign buf_in = {i_byte, i_byte_addr, i_byte_src, i_cfg_index, i_cfg_alternate,
                   i_byte_lane, i_last};

  // The buffer takes up to two items from the stream while the engine waits to start.
  fic_skid_buf #(
    .WIDTH (ITEM_W)
  ) u_buf (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_valid   (i_byte_valid),
    .o_ready   (o_byte_ready),
    .i_data    (buf_in),
    .o_valid   (buf_valid),
    .i_ready   (buf_ready),
    .o_data    (buf_out)
  );

  // Field split of the buffered item.
  wire [7:0]  b_data = buf_out[ITEM_W-1 -: 8];
  wire [31:0] b_addr = buf_out[ITEM_W-9 -: 32];
  wire [1:0]  b_src  = buf_out[8:7];
  wire [2:0]  b_idx  = buf_out[6:4];
  wire        b_alt  = buf_out[3];
  wire [1:0]  b_lane = buf_out[2:1];
  wire        b_last = buf_out[0];

  // Bytes are consumed only while a computation runs.
  assign buf_ready = (state == fic_pkg::FIC_ST_RUN);
  wire take = buf_valid && buf_ready && i_ce;

  // Upper configuration index depends on the variant group.
  wire [2:0] cfg_hi = (VARIANT == fic_pkg::FIC_VAR_DUAL_BOOT_X) ?
                      fic_pkg::FIC_CFG_HI_EXT : fic_pkg::FIC_CFG_HI_BASE;
  wire dual_boot = (VARIANT == fic_pkg::FIC_VAR_DUAL_BOOT) ||
                   (VARIANT == fic_pkg::FIC_VAR_DUAL_BOOT_X);

  // Boot flash exclusion windows per variant.
  wire in_db_win = ((b_addr & fic_pkg::FIC_DB_WIN_MASK) == fic_pkg::FIC_DB_WIN_BASE);
  wire in_dp_win = (b_addr >= fic_pkg::FIC_DP_WIN_LO) &&
                   (b_addr <= fic_pkg::FIC_DP_WIN_HI);
  wire in_sb_win = (b_addr > BOOT_END - 32'(fic_pkg::FIC_SB_CFG_BYTES)) &&
                   (b_addr <= BOOT_END);
  wire boot_skip = dual_boot ? in_db_win :
                   (VARIANT == fic_pkg::FIC_VAR_DUAL_PANEL) ? in_dp_win : in_sb_win;

  // Configuration bytes count only within range and only for primary words.
  wire cfg_ok = (b_idx <= cfg_hi) && !b_alt;
  wire [7:0] cfg_byte = fic_lane({24'h000000, b_data} << {b_lane, 3'h0} &
                                 fic_cfg_mask(b_idx), b_lane);
  wire [7:0] id_byte  = fic_lane({24'h000000, b_data} << {b_lane, 3'h0} &
                                 ID_MASK, b_lane);

  // Next sums; additions wrap at 32 bits.
  wire [31:0] next_program_flash_sum = program_flash_sum + {24'h000000, b_data};
  wire [31:0] next_boot_flash_sum    = boot_flash_sum + {24'h000000, b_data};
  wire [31:0] next_masked_config_sum = masked_config_sum + {24'h000000, cfg_byte};
  wire [31:0] next_id_sum            = id_sum + {24'h000000, id_byte};
  wire [31:0] total = program_flash_sum + boot_flash_sum + masked_config_sum + id_sum;
  wire [31:0] next_checksum = protect_q ? 32'h0 : (~total + 32'h1);

  // Controller transitions.
  always_comb
  begin
    next_state = state;
    case (state)
      fic_pkg::FIC_ST_IDLE: if (i_start) next_state = fic_pkg::FIC_ST_RUN;
      fic_pkg::FIC_ST_RUN:  if (take && b_last) next_state = fic_pkg::FIC_ST_DONE;
      fic_pkg::FIC_ST_DONE: next_state = i_start ? fic_pkg::FIC_ST_RUN : fic_pkg::FIC_ST_IDLE;
      default:              next_state = fic_pkg::FIC_ST_IDLE;
    endcase
  end

  assign o_busy = (state == fic_pkg::FIC_ST_RUN);
  assign o_done = (state == fic_pkg::FIC_ST_DONE);

  // State, protect latch and result register.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state      <= fic_pkg::FIC_ST_IDLE;
      protect_q  <= 1'b0;
      o_checksum <= 32'h00000000;
    end
    else if (i_ce)
    begin
      state <= next_state;
      if (i_start && state != fic_pkg::FIC_ST_RUN)
        protect_q <= i_code_protect;
      if (state == fic_pkg::FIC_ST_DONE)
        o_checksum <= next_checksum;
    end
  end

  // Partial sums; a start clears them all before any byte is taken.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || (i_ce && i_start && state != fic_pkg::FIC_ST_RUN))
    begin
      program_flash_sum <= fic_pkg::FIC_SUM_RESET;
      boot_flash_sum    <= fic_pkg::FIC_SUM_RESET;
      masked_config_sum <= fic_pkg::FIC_SUM_RESET;
      id_sum            <= fic_pkg::FIC_SUM_RESET;
    end
    else if (take)
    begin
      case (b_src)
        fic_pkg::FIC_SRC_PROG: program_flash_sum <= next_program_flash_sum;
        fic_pkg::FIC_SRC_BOOT: if (!boot_skip) boot_flash_sum <= next_boot_flash_sum;
        fic_pkg::FIC_SRC_CFG:  if (cfg_ok) masked_config_sum <= next_masked_config_sum;
        fic_pkg::FIC_SRC_ID:   id_sum <= next_id_sum;
        default:               id_sum <= id_sum;
      endcase
    end
  end

  // A skipped boot byte never moves the boot sum.
  property p_boot_skip;
    @(posedge i_clk_sys) disable iff (i_rst)
      (take && b_src == fic_pkg::FIC_SRC_BOOT && boot_skip && !i_start)
        |=> $stable(boot_flash_sum);
  endproperty
  a_boot_skip: assert property (p_boot_skip) else $error("skipped boot byte summed");

  // Protected runs end in a zero result.
  property p_protect_zero;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && o_done && protect_q) |=> (o_checksum == 32'h00000000);
  endproperty
  a_protect_zero: assert property (p_protect_zero)
    else $error("protected checksum nonzero");

  // Unprotected result plus total is zero modulo two to the thirty-second.
  property p_twos;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && o_done && !protect_q && !i_start) |=> (o_checksum + total == 32'h00000000);
  endproperty
  a_twos: assert property (p_twos) else $error("result not two's complement");

  // Alternate configuration bytes never move the masked sum.
  property p_alt;
    @(posedge i_clk_sys) disable iff (i_rst)
      (take && b_src == fic_pkg::FIC_SRC_CFG && b_alt && !i_start) |=> $stable(masked_config_sum);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate word summed");

  // A start clears the program sum.
  property p_clear;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_ce && i_start && state != fic_pkg::FIC_ST_RUN) |=> (program_flash_sum == 32'h00000000);
  endproperty
  a_clear: assert property (p_clear) else $error("sum not cleared on start");

  // Configuration words above the variant's upper index never move the masked sum.
  property p_cfg_range;
    @(posedge i_clk_sys) disable iff (i_rst)
      (take && b_src == fic_pkg::FIC_SRC_CFG && b_idx > cfg_hi && !i_start)
        |=> $stable(masked_config_sum);
  endproperty
  a_cfg_range: assert property (p_cfg_range) else $error("config word out of range");
endmodule
`default_nettype wire

// ---- tb/fic_src_model.sv ----
// Memory read stream model that feeds tagged bytes to the checksum engine.
`timescale 1ns/1ps
`default_nettype none
module fic_src_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic      [7:0]  o_byte,
  output logic      [31:0] o_addr,
  output logic      [1:0]  o_src,
  output logic      [2:0]  o_idx,
  output logic      [1:0]  o_lane,
  output logic             o_alt,
  output logic             o_last
);
  // Lines start idle; data lines carry a pattern rather than a stale value.
  initial
  begin
    o_valid = 1'b0;
    o_byte  = 8'h5A;
    o_addr  = 32'hA5A5A5A5;
    o_src   = 2'h0;
    o_idx   = 3'h0;
    o_lane  = 2'h0;
    o_alt   = 1'b0;
    o_last  = 1'b0;
  end
  // One item is held for up to twenty edges until one samples ready high, then released with byte and address inverted.
  task automatic send(input logic [7:0] b, input logic [31:0] a, input logic [1:0] s,
                      input logic [2:0] x, input logic [1:0] l, input logic al,
                      input logic la, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge i_clk_sys);
    o_valid <= 1'b1;
    o_byte  <= b;
    o_addr  <= a;
    o_src   <= s;
    o_idx   <= x;
    o_lane  <= l;
    o_alt   <= al;
    o_last  <= la;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge i_clk_sys);
      ok = i_ready;
    end
    o_valid <= 1'b0;
    o_byte  <= ~b;
    o_addr  <= ~a;
    o_last  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_fic_checksum.sv ----
// Self-checking testbench for the flash image checksum engine.
`timescale 1ns/1ps
`default_nettype none
module test_fic_checksum;
  localparam logic [31:0] BEND = 32'h1FC02FFF;
  localparam logic [31:0] IDM  = 32'h0FFFFFFF;
  localparam logic [31:0] CM0  = 32'h0000FF00;
  logic        i_clk_sys;
  logic        i_rst;
  logic        i_start;
  logic        i_code_protect;
  logic        valid;
  logic        ready;
  logic [7:0]  data;
  logic [31:0] addr;
  logic [1:0]  src;
  logic [2:0]  idx;
  logic [1:0]  lane;
  logic        alt;
  logic        last;
  logic        busy;
  logic        done;
  logic [31:0] sum;
  logic [31:0] sum_db;
  logic [31:0] sum_dp;
  logic [31:0] sum_dx;
  logic        ce;
  int          errors;
  int          n_tests;
  fic_checksum #(.BOOT_END(BEND), .ID_MASK(IDM), .CFG_MASK0(CM0)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce), .i_start(i_start),
    .i_code_protect(i_code_protect), .i_byte_valid(valid), .o_byte_ready(ready),
    .i_byte(data), .i_byte_addr(addr), .i_byte_src(src), .i_cfg_index(idx),
    .i_cfg_alternate(alt), .i_byte_lane(lane), .i_last(last), .o_busy(busy),
    .o_done(done), .o_checksum(sum));
  // The other variants share the stream; their handshake matches the first engine's.
  fic_checksum #(.VARIANT(fic_pkg::FIC_VAR_DUAL_BOOT), .BOOT_END(BEND), .ID_MASK(IDM),
    .CFG_MASK0(CM0)) i_dut_db (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce), .i_start(i_start),
    .i_code_protect(i_code_protect), .i_byte_valid(valid), .o_byte_ready(),
    .i_byte(data), .i_byte_addr(addr), .i_byte_src(src), .i_cfg_index(idx),
    .i_cfg_alternate(alt), .i_byte_lane(lane), .i_last(last), .o_busy(),
    .o_done(), .o_checksum(sum_db));
  fic_checksum #(.VARIANT(fic_pkg::FIC_VAR_DUAL_PANEL), .BOOT_END(BEND), .ID_MASK(IDM),
    .CFG_MASK0(CM0)) i_dut_dp (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce), .i_start(i_start),
    .i_code_protect(i_code_protect), .i_byte_valid(valid), .o_byte_ready(),
    .i_byte(data), .i_byte_addr(addr), .i_byte_src(src), .i_cfg_index(idx),
    .i_cfg_alternate(alt), .i_byte_lane(lane), .i_last(last), .o_busy(),
    .o_done(), .o_checksum(sum_dp));
  fic_checksum #(.VARIANT(fic_pkg::FIC_VAR_DUAL_BOOT_X), .BOOT_END(BEND), .ID_MASK(IDM),
    .CFG_MASK0(CM0)) i_dut_dx (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce), .i_start(i_start),
    .i_code_protect(i_code_protect), .i_byte_valid(valid), .o_byte_ready(),
    .i_byte(data), .i_byte_addr(addr), .i_byte_src(src), .i_cfg_index(idx),
    .i_cfg_alternate(alt), .i_byte_lane(lane), .i_last(last), .o_busy(),
    .o_done(), .o_checksum(sum_dx));
  fic_src_model i_src (
    .i_clk_sys(i_clk_sys), .i_ready(ready), .o_valid(valid), .o_byte(data),
    .o_addr(addr), .o_src(src), .o_idx(idx), .o_lane(lane), .o_alt(alt), .o_last(last));
  // Free-running system clock at 25 MHz.
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  // Start is held for one edge; protect is sampled with it.
  task automatic go(input logic cp);
    @(posedge i_clk_sys);
    i_start        <= 1'b1;
    i_code_protect <= cp;
    @(posedge i_clk_sys);
    i_start        <= 1'b0;
  endtask
  task automatic put(input logic [7:0] b, input logic [31:0] a, input logic [1:0] s,
                     input logic [2:0] x, input logic [1:0] l, input logic al, input logic la);
    logic ok;
    i_src.send(b, a, s, x, l, al, la, ok);
    if (ok !== 1'b1)
    begin
      check("item_taken", 32'h1, 32'(ok));
      report_and_stop();
    end
  endtask
  // The result is read one edge after the done pulse, as the engine registers it then.
  task automatic finish(input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2,
                        input logic [31:0] e3);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(posedge i_clk_sys);
      #1;
      if (done === 1'b1)
        break;
    end
    check("done", 32'h1, 32'(done));
    if (done !== 1'b1)
      report_and_stop();
    else
    begin
      check("busy_at_done", 32'h0, 32'(busy));
      @(posedge i_clk_sys);
      #1;
      check("done_pulse", 32'h0, 32'(done));
      check("checksum", e0, sum);
      check("checksum_db", e1, sum_db);
      check("checksum_dp", e2, sum_dp);
      check("checksum_dx", e3, sum_dx);
    end
  endtask
  task automatic s_image();
    logic [31:0] s;
    s = 32'h0 + 8'hA5 + 8'h3C + 8'h11 + 8'h66 + (8'hFF & CM0[15:8]) + (8'hFF & CM0[7:0])
        + 8'h12 + (8'hFF & IDM[31:24]) + (8'h53 & IDM[7:0]);
    go(1'b0);
    #1;
    check("busy", 32'h1, 32'(busy));
    put(8'hA5, 32'h1D000000, fic_pkg::FIC_SRC_PROG, 3'h0, 2'h0, 1'b0, 1'b0);
    put(8'h3C, 32'h1D000001, fic_pkg::FIC_SRC_PROG, 3'h0, 2'h1, 1'b0, 1'b0);
    put(8'h11, 32'h1FC00000, fic_pkg::FIC_SRC_BOOT, 3'h0, 2'h0, 1'b0, 1'b0);
    put(8'h77, BEND, fic_pkg::FIC_SRC_BOOT, 3'h0, 2'h3, 1'b0, 1'b0);
    put(8'h55, BEND - 32'hF, fic_pkg::FIC_SRC_BOOT, 3'h0, 2'h0, 1'b0, 1'b0);
    put(8'h66, BEND - 32'h10, fic_pkg::FIC_SRC_BOOT, 3'h0, 2'h3, 1'b0, 1'b0);
    put(8'h21, 32'h1FC4FFFF, fic_pkg::FIC_SRC_BOOT, 3'h0, 2'h3, 1'b0, 1'b0);
    put(8'h42, 32'h1FC03F00, fic_pkg::FIC_SRC_BOOT, 3'h0, 2'h0, 1'b0, 1'b0);
    put(8'hFF, 32'h0, fic_pkg::FIC_SRC_CFG, 3'h0, 2'h1, 1'b0, 1'b0);
    put(8'hFF, 32'h0, fic_pkg::FIC_SRC_CFG, 3'h0, 2'h0, 1'b0, 1'b0);
    put(8'h12, 32'h0, fic_pkg::FIC_SRC_CFG, 3'h3, 2'h0, 1'b0, 1'b0);
    put(8'h40, 32'h0, fic_pkg::FIC_SRC_CFG, 3'h4, 2'h0, 1'b0, 1'b0);
    put(8'h80, 32'h0, fic_pkg::FIC_SRC_CFG, 3'h0, 2'h2, 1'b1, 1'b0);
    put(8'hFF, 32'h0, fic_pkg::FIC_SRC_ID, 3'h0, 2'h3, 1'b0, 1'b0);
    put(8'h53, 32'h0, fic_pkg::FIC_SRC_ID, 3'h0, 2'h0, 1'b0, 1'b1);
    // Single boot drops its last sixteen bytes, dual boot its high window, dual panel
    // its fixed window; only the extended group adds configuration word four.
    finish(~(s + 32'h21 + 32'h42) + 32'h1,
           ~(s + 32'h77 + 32'h55 + 32'h42) + 32'h1,
           ~(s + 32'h77 + 32'h55 + 32'h21) + 32'h1,
           ~(s + 32'h77 + 32'h55 + 32'h42 + 32'h40) + 32'h1);
  endtask
  // A low clock enable holds the run: the parked last byte is not taken until it rises.
  task automatic s_protect();
    go(1'b1);
    put(8'hAA, 32'h1D000000, fic_pkg::FIC_SRC_PROG, 3'h0, 2'h0, 1'b0, 1'b1);
    ce <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    ce <= 1'b1;
    #1;
    check("frozen_busy", 32'h1, 32'(busy));
    finish(32'h0, 32'h0, 32'h0, 32'h0);
  endtask
  // Two items parked while idle fill the buffer; the new run starts from a cleared sum.
  task automatic s_buffer();
    put(8'h01, 32'h1D000000, fic_pkg::FIC_SRC_PROG, 3'h0, 2'h0, 1'b0, 1'b0);
    put(8'h02, 32'h1D000001, fic_pkg::FIC_SRC_PROG, 3'h0, 2'h1, 1'b0, 1'b0);
    @(posedge i_clk_sys);
    #1;
    check("ready", 32'h0, 32'(ready));
    go(1'b0);
    put(8'h03, 32'h1D000002, fic_pkg::FIC_SRC_PROG, 3'h0, 2'h2, 1'b0, 1'b1);
    finish(~32'h6 + 32'h1, ~32'h6 + 32'h1, ~32'h6 + 32'h1, ~32'h6 + 32'h1);
  endtask
  // Main sequence: reset for twenty cycles, then each scenario in turn.
  initial
  begin
    errors         = 0;
    n_tests        = 0;
    i_rst          = 1'b1;
    i_start        = 1'b0;
    i_code_protect = 1'b0;
    ce             = 1'b1;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    check("reset_sum", 32'h0, sum);
    check("reset_ready", 32'h1, 32'(ready));
    s_image();
    s_protect();
    s_buffer();
    report_and_stop();
  end
endmodule
`default_nettype wire
